/* File: verilog/lda_pkg.sv */
// Shared constants, field layouts and carrier types of the doubleword load address unit
package lda_pkg;

    // ==========================================================
    // Instruction word encoding
    localparam logic [1:0] TAG_UNALIGNED = 2'b01;
    localparam logic [1:0] TAG_ALIGNED = 2'b10;
    localparam logic [2:0] LDST_ALIGNED_DW = 3'b110;
    localparam logic [2:0] LDST_UNALIGNED_DW = 3'b010;
    localparam logic [2:0] COND_ALWAYS = 3'h0;
    localparam int DW_SHIFT = 3;
    localparam int UCST_W = 5;

    // Mode field bit meanings
    localparam int MODE_MODIFY = 3;
    localparam int MODE_REGOFF = 2;
    localparam int MODE_POST = 1;
    localparam int MODE_ADD = 0;

    // ==========================================================
    // Addressing-mode control register layout
    localparam logic [1:0] AMR_LINEAR = 2'h0;
    localparam logic [1:0] AMR_CIRC_BK0 = 2'h1;
    localparam logic [1:0] AMR_CIRC_BK1 = 2'h2;
    localparam int AMR_FIELD_W = 2;
    localparam int AMR_B_LSB = 8;
    localparam int AMR_BK0_LSB = 16;
    localparam int AMR_BK1_LSB = 21;
    localparam int BK_W = 5;
    localparam logic [4:0] CIRC_IDX_LO = 5'h04;
    localparam logic [4:0] CIRC_IDX_HI = 5'h07;

    // ==========================================================
    // APB register map
    localparam int APB_AW = 12;
    localparam logic [11:0] REG_AMR = 12'h000;
    localparam logic [11:0] REG_CTRL = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00c;
    localparam logic [11:0] REG_REFUSED = 12'h010;
    localparam logic [31:0] AMR_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_EN = 0;
    localparam int ST_CONFLICT = 0;
    localparam int ST_LATE = 1;
    localparam int ST_ILLEGAL = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_STICKY_W = 3;

    // ==========================================================
    // Pipeline timing: issue cycle is execute_stage_one
    localparam int DATA_DELAY_SLOTS = 4;
    localparam int ADDR_DELAY_SLOTS = 0;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [2:0] creg;
        logic z;
        logic [3:0] dst;
        logic offset_scale_select;
        logic [4:0] base;
        logic [4:0] offset;
        logic [3:0] mode;
        logic r;
        logic y;
        logic [2:0] ldst;
        logic [1:0] tag;
        logic s;
        logic p;
    } lda_instr_s;

    typedef struct packed {
        logic side;
        logic [4:0] even_idx;
    } lda_dst_s;

endpackage

/* File: verilog/lda_agen.sv */
// Effective address and base update arithmetic for one load
`timescale 1ns/1ps
`default_nettype none
module lda_agen
    import lda_pkg::*;
#(
    parameter int AW = 32
) (
    // Operands
    input wire logic [AW-1:0] base_val,
    input wire logic [AW-1:0] off_reg_val,
    input wire logic [UCST_W-1:0] short_unsigned_constant,
    input wire logic [3:0] mode,
    input wire logic scale,
    // Circular control
    input wire logic circ_en,
    input wire logic [BK_W-1:0] circ_bk,
    // Results
    output logic [AW-1:0] addr,
    output logic [AW-1:0] new_base,
    output logic base_we
);

    // ==========================================================
    // Block mask: block of 2^(bk+1) bytes, shift past width gives all ones
    function automatic logic [AW-1:0] circ_mask(input logic [BK_W-1:0] bk);
        circ_mask = ~({AW{1'b1}} << ({1'b0, bk} + 6'h01));
    endfunction

    logic [AW-1:0] off_raw;
    logic [AW-1:0] off_sc;
    logic [AW-1:0] lin;
    logic [AW-1:0] mask;

    always_comb begin
        // Register offset or zero-extended constant
        off_raw = mode[MODE_REGOFF] ? off_reg_val : AW'(short_unsigned_constant);
        off_sc = scale ? (off_raw << DW_SHIFT) : off_raw;
        lin = mode[MODE_ADD] ? (base_val + off_sc) : (base_val - off_sc);
        mask = circ_mask(circ_bk);
        // Only the bits inside the block wrap; the upper part of base is kept
        new_base = circ_en ? ((base_val & ~mask) | (lin & mask)) : lin;
        addr = mode[MODE_POST] ? base_val : new_base;
        base_we = mode[MODE_MODIFY];
    end

endmodule
`default_nettype wire

/* File: verilog/lda_pipe.sv */
// Stage carrier from the second to the fifth execute stage and pair writeback
`timescale 1ns/1ps
`default_nettype none
module lda_pipe
    import lda_pkg::*;
#(
    parameter int DEPTH = DATA_DELAY_SLOTS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Entry from execute_stage_one
    input wire logic push,
    input wire lda_dst_s push_dst,
    // Memory answer, expected while the load sits in stage four
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    // Writeback in execute_stage_five
    output logic wb_valid,
    output lda_dst_s wb_dst,
    output logic [31:0] wb_lo,
    output logic [31:0] wb_hi,
    output logic late,
    output logic busy
);

    logic [DEPTH-1:0] vld_q;
    lda_dst_s dst_q [DEPTH];
    logic [63:0] data_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                dst_q[i] <= '0;
            end
        end else if (ce) begin
            vld_q <= {vld_q[DEPTH-2:0], push};
            dst_q[0] <= push_dst;
            for (int i = 1; i < DEPTH; i++) begin
                dst_q[i] <= dst_q[i-1];
            end
        end
    end

    // Data is sampled at the end of stage four so stage five can write it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= '0;
        end else if (ce && vld_q[DEPTH-2]) begin
            data_q <= mem_rdata;
        end
    end

    assign late = ce && vld_q[DEPTH-2] && !mem_rvalid;
    assign busy = |vld_q;
    assign wb_valid = vld_q[DEPTH-1];
    assign wb_dst = dst_q[DEPTH-1];
    assign wb_lo = data_q[31:0];
    assign wb_hi = data_q[63:32];

endmodule
`default_nettype wire

/* File: verilog/lda_top.sv */
// Decode, address generation, APB registers and stage control of doubleword loads
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Read and update base in stage one; pair in five
// - Unaligned load accepts any byte address
// - Address is base plus or minus register or constant offset
// - Unit-side bit picks data unit and operand file
// - Scale-select set shifts offset left by three
// - Post modes access old base, others the sum
// - Circular arithmetic for indices four to seven
// - Destination names an even/odd pair
// - Low word to even, high word to odd
// - Destination-side bit alone picks destination file
// - Four-bit mode field decodes offset and update kind
module lda_top
    import lda_pkg::*;
#(
    parameter int AW = 32,
    parameter int CNT_W = 32
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction issue
    input wire logic iss_valid,
    input wire logic [31:0] iss_word,
    input wire logic iss_other_mem,
    // Operand and condition read
    output logic rf_side,
    output logic [4:0] rf_base_idx,
    output logic [4:0] rf_off_idx,
    input wire logic [AW-1:0] rf_base_val,
    input wire logic [AW-1:0] rf_off_val,
    output logic [2:0] cond_sel,
    input wire logic [31:0] cond_val,
    // Base register update
    output logic base_we,
    output logic base_side,
    output logic [4:0] base_idx,
    output logic [AW-1:0] base_val,
    // Memory request and answer
    output logic mem_req,
    output logic [AW-1:0] mem_addr,
    output logic mem_unaligned,
    output logic mem_unit,
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    // Pair writeback
    output logic pair_we,
    output logic pair_side,
    output logic [4:0] pair_even_idx,
    output logic [4:0] pair_odd_idx,
    output logic [31:0] pair_lo,
    output logic [31:0] pair_hi
);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            strb_merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic logic [1:0] amr_field(input logic [31:0] addressing_mode_control_reg, input logic side,
                                             input logic [4:0] idx);
        logic [1:0] k;
        k = idx[1:0];
        amr_field = side ? addressing_mode_control_reg[AMR_B_LSB + AMR_FIELD_W*k +: AMR_FIELD_W]
                         : addressing_mode_control_reg[AMR_FIELD_W*k +: AMR_FIELD_W];
    endfunction

    // ==========================================================
    // Registers
    logic [31:0] addressing_mode_control_reg_q;
    logic [31:0] ctrl_q;
    logic [ST_STICKY_W-1:0] sticky_q;
    logic [CNT_W-1:0] load_cnt_q;
    logic [CNT_W-1:0] refused_cnt_q;

    logic apb_wr;
    logic apb_rd;
    logic addr_hit;
    logic pipe_busy;
    logic pipe_late;

    // Register access completes in one access cycle unless the unit is frozen
    assign pready = ce;
    assign apb_wr = psel && penable && pwrite && ce;
    assign apb_rd = psel && penable && !pwrite;
    assign addr_hit = (paddr == REG_AMR) || (paddr == REG_CTRL) || (paddr == REG_STATUS)
                   || (paddr == REG_COUNT) || (paddr == REG_REFUSED);
    assign pslverr = psel && penable && !addr_hit;

    always_comb begin
        prdata = '0;
        if (apb_rd) begin
            case (paddr)
                REG_AMR: prdata = addressing_mode_control_reg_q;
                REG_CTRL: prdata = ctrl_q;
                REG_STATUS: prdata = {28'h0, pipe_busy, sticky_q};
                REG_COUNT: prdata = 32'(load_cnt_q);
                REG_REFUSED: prdata = 32'(refused_cnt_q);
                default: prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addressing_mode_control_reg_q <= AMR_RST;
        end else if (apb_wr && paddr == REG_AMR) begin
            addressing_mode_control_reg_q <= strb_merge(addressing_mode_control_reg_q,
                                                        pwdata, pstrb);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (apb_wr && paddr == REG_CTRL) begin
            ctrl_q <= strb_merge(ctrl_q, pwdata, pstrb) & CTRL_RST;
        end
    end

    // ==========================================================
    // Decode in execute_stage_one
    lda_instr_s ins;
    logic is_unal;
    logic is_al;
    logic known;
    logic mode_ok;
    logic cond_true;
    logic unit_on;
    logic exec;
    logic illegal;
    logic conflict;
    logic in_circ;
    logic [1:0] amode;
    logic circ_en;
    logic [BK_W-1:0] circ_bk;
    logic [AW-1:0] ag_addr;
    logic [AW-1:0] ag_new_base;
    logic ag_base_we;

    assign ins = lda_instr_s'(iss_word);
    assign unit_on = ctrl_q[CTRL_EN];
    assign is_unal = ins.tag == TAG_UNALIGNED && ins.ldst == LDST_UNALIGNED_DW && ins.r;
    // Aligned form keeps the low bit of the destination field, here the scale bit, at zero
    assign is_al = ins.tag == TAG_ALIGNED && ins.ldst == LDST_ALIGNED_DW && ins.r;
    assign known = is_unal || is_al;
    // Codes 0x1x with the post bit set and no modify bit are undefined
    assign mode_ok = ins.mode[MODE_MODIFY] || !ins.mode[MODE_POST];

    // Condition register value: nonzero test, or zero test when z is set
    assign cond_sel = ins.creg;
    assign cond_true = (ins.creg == COND_ALWAYS) ? !ins.z
                     : (ins.z ? (cond_val == 32'h0) : (cond_val != 32'h0));

    assign illegal = iss_valid && unit_on && known
                  && (!mode_ok || (is_al && ins.offset_scale_select));
    assign exec = iss_valid && unit_on && known && !illegal && cond_true;
    // The issuing side owns this; it is only recorded here
    assign conflict = iss_valid && unit_on && is_unal && cond_true && iss_other_mem;

    // Operands come from the file of the chosen data unit
    assign rf_side = ins.y;
    assign rf_base_idx = ins.base;
    assign rf_off_idx = ins.offset;

    assign in_circ = ins.base >= CIRC_IDX_LO && ins.base <= CIRC_IDX_HI;
    assign amode = amr_field(addressing_mode_control_reg_q, ins.y, ins.base);
    assign circ_en = in_circ && (amode == AMR_CIRC_BK0 || amode == AMR_CIRC_BK1);
    assign circ_bk = (amode == AMR_CIRC_BK1)
                   ? addressing_mode_control_reg_q[AMR_BK1_LSB +: BK_W]
                   : addressing_mode_control_reg_q[AMR_BK0_LSB +: BK_W];

    lda_agen #(
        .AW(AW)
    ) u_agen (
        .base_val(rf_base_val),
        .off_reg_val(rf_off_val),
        .short_unsigned_constant(ins.offset),
        .mode(ins.mode),
        .scale(is_al || ins.offset_scale_select),
        .circ_en(circ_en),
        .circ_bk(circ_bk),
        .addr(ag_addr),
        .new_base(ag_new_base),
        .base_we(ag_base_we)
    );

    // ==========================================================
    // Base update, visible to the very next instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_we <= 1'b0;
            base_side <= 1'b0;
            base_idx <= '0;
            base_val <= '0;
        end else if (ce) begin
            base_we <= exec && ag_base_we;
            if (exec && ag_base_we) begin
                base_side <= ins.y;
                base_idx <= ins.base;
                base_val <= ag_new_base;
            end
        end
    end

    // ==========================================================
    // Memory request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req <= 1'b0;
            mem_addr <= '0;
            mem_unaligned <= 1'b0;
            mem_unit <= 1'b0;
        end else if (ce) begin
            mem_req <= exec;
            if (exec) begin
                // Aligned form ignores the low three address bits; unaligned keeps all
                mem_addr <= is_unal ? ag_addr : {ag_addr[AW-1:DW_SHIFT], 3'h0};
                mem_unaligned <= is_unal;
                mem_unit <= ins.y;
            end
        end
    end

    // ==========================================================
    // Stages two to five and the pair write
    lda_dst_s push_dst;
    lda_dst_s wb_dst;
    logic wb_valid;

    assign push_dst.side = ins.s;
    assign push_dst.even_idx = {ins.dst, 1'b0};

    lda_pipe #(
        .DEPTH(DATA_DELAY_SLOTS)
    ) u_pipe (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .push(exec),
        .push_dst(push_dst),
        .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata),
        .wb_valid(wb_valid),
        .wb_dst(wb_dst),
        .wb_lo(pair_lo),
        .wb_hi(pair_hi),
        .late(pipe_late),
        .busy(pipe_busy)
    );

    assign pair_we = wb_valid;
    assign pair_side = wb_dst.side;
    assign pair_even_idx = wb_dst.even_idx;
    assign pair_odd_idx = wb_dst.even_idx | 5'h01;

    // ==========================================================
    // Status: hardware set beats a write-one clear in the same cycle
    logic [ST_STICKY_W-1:0] st_set;
    logic [ST_STICKY_W-1:0] st_clr;

    always_comb begin
        st_set = '0;
        st_set[ST_CONFLICT] = ce && conflict;
        st_set[ST_LATE] = pipe_late;
        st_set[ST_ILLEGAL] = ce && illegal;
        st_clr = (apb_wr && paddr == REG_STATUS) ? pwdata[ST_STICKY_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky_q <= '0;
        end else if (ce) begin
            sticky_q <= (sticky_q & ~st_clr) | st_set;
        end
    end

    // ==========================================================
    // Counters: executed loads, and issues refused while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cnt_q <= '0;
        end else if (ce && exec) begin
            load_cnt_q <= load_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_cnt_q <= '0;
        end else if (ce && iss_valid && known && !unit_on) begin
            refused_cnt_q <= refused_cnt_q + CNT_W'(1);
        end
    end

endmodule
`default_nettype wire

/* File: tb/lda_top_sva.sv */
// Assertion checker for the doubleword load address unit
`timescale 1ns/1ps
`default_nettype none
module lda_top_sva
    import lda_pkg::*;
#(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Issue and operand read
    input wire logic iss_valid,
    input wire logic [31:0] iss_word,
    input wire logic rf_side,
    input wire logic [4:0] rf_base_idx,
    input wire logic [4:0] rf_off_idx,
    input wire logic [AW-1:0] rf_base_val,
    input wire logic [AW-1:0] rf_off_val,
    input wire logic [31:0] cond_val,
    // Results
    input wire logic base_we,
    input wire logic [AW-1:0] base_val,
    input wire logic mem_req,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [63:0] mem_rdata,
    input wire logic pair_we,
    input wire logic pair_side,
    input wire logic [4:0] pair_even_idx,
    input wire logic [4:0] pair_odd_idx,
    input wire logic [31:0] pair_lo,
    input wire logic [31:0] pair_hi
);
    // ==========================================================
    // Linear sum of the word in stage one; circular bases excluded
    logic [AW-1:0] off_c;
    logic [AW-1:0] sum_c;
    logic lin_c;
    always_comb begin
        off_c = iss_word[11] ? rf_off_val : AW'(iss_word[17:13]);
        off_c = off_c << (iss_word[23] ? DW_SHIFT : 0);
        sum_c = iss_word[9] ? rf_base_val + off_c : rf_base_val - off_c;
        lin_c = iss_word[3:2] == TAG_UNALIGNED && rf_base_idx[4:2] != 3'b001;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_req_lat;
        mem_req |-> $past(iss_valid);
    endproperty
    a_req_lat: assert property (p_req_lat) else $error("req without issue");
    property p_wb_lat;
        pair_we |-> $past(mem_req, 3);
    endproperty
    a_wb_lat: assert property (p_wb_lat) else $error("pair write late");
    property p_pair_data;
        pair_we |-> {pair_hi, pair_lo} == $past(mem_rdata);
    endproperty
    a_pair_data: assert property (p_pair_data) else $error("pair halves wrong");
    property p_decode;
        iss_valid |-> rf_side == iss_word[7] && rf_base_idx == iss_word[22:18]
            && rf_off_idx == iss_word[17:13];
    endproperty
    a_decode: assert property (p_decode) else $error("operand decode");
    property p_dst_side;
        pair_we |-> pair_side == $past(iss_word[1], 4)
            && pair_even_idx == {$past(iss_word[27:24], 4), 1'b0}
            && pair_odd_idx == {$past(iss_word[27:24], 4), 1'b1};
    endproperty
    a_dst_side: assert property (p_dst_side) else $error("pair dest");
    property p_nop;
        iss_valid && (iss_word[31:29] == COND_ALWAYS ? iss_word[28]
            : (iss_word[28] ? cond_val != 0 : cond_val == 0)) |=> !mem_req && !base_we;
    endproperty
    a_nop: assert property (p_nop) else $error("false cond acted");
    property p_post;
        mem_req && $past(iss_word[10]) && $past(iss_word[3:2]) == TAG_UNALIGNED
            |-> mem_addr == $past(rf_base_val);
    endproperty
    a_post: assert property (p_post) else $error("post address");
    property p_pre;
        mem_req && !$past(iss_word[10]) && $past(lin_c) |-> mem_addr == $past(sum_c);
    endproperty
    a_pre: assert property (p_pre) else $error("offset address");
    property p_base;
        base_we && $past(lin_c) |-> $past(iss_word[12]) && base_val == $past(sum_c);
    endproperty
    a_base: assert property (p_base) else $error("base update wrong");
    c_modify: cover property (mem_req && base_we);
    c_pair_b: cover property (pair_we && pair_side);
    c_scaled: cover property (iss_valid && iss_word[23]);
endmodule

bind lda_top lda_top_sva #(.AW(AW)) u_lda_top_sva (.*);
`default_nettype wire

/* File: tb/lda_mem_model.sv */
// Behavioural data memory answering doubleword loads
`timescale 1ns/1ps
`default_nettype none
module lda_mem_model #(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request and slow-answer control
    input wire logic mem_req,
    input wire logic [AW-1:0] mem_addr,
    input wire logic late,
    // Answer
    output logic mem_rvalid,
    output logic [63:0] mem_rdata
);
    logic v1_q;
    logic [AW-1:0] a1_q;
    function automatic logic [63:0] fetch(input logic [AW-1:0] a);
        logic [63:0] d;
        for (int i = 0; i < 8; i++) begin
            d[8*i+:8] = 8'(a + AW'(i)) ^ 8'ha5;
        end
        return d;
    endfunction
    // Answer in stage four; idle data toggles so stale bits never match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v1_q <= 1'b0;
            a1_q <= '0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 64'h0;
        end else begin
            v1_q <= mem_req;
            a1_q <= mem_addr;
            mem_rvalid <= v1_q && !late;
            mem_rdata <= v1_q ? fetch(a1_q) : ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: tb/lda_top_bench.sv */
// Self-checking bench for the doubleword load address unit
`timescale 1ns/1ps
`default_nettype none
module lda_top_bench
    import lda_pkg::*;
;
    logic pclk, presetn, ce = 1'b1, psel, penable, pwrite, pready, pslverr, late, er;
    logic iss_valid, iss_other_mem, rf_side, base_we, base_side, mem_req, mem_unaligned;
    logic mem_unit, mem_rvalid, pair_we, pair_side;
    logic [3:0] pstrb = 4'hf;
    logic [11:0] paddr;
    logic [4:0] rf_base_idx, rf_off_idx, base_idx, pair_even_idx, pair_odd_idx;
    logic [2:0] cond_sel;
    logic [31:0] pwdata, prdata, iss_word, rf_base_val, rf_off_val = 32'h5, cond_val, rd;
    logic [31:0] base_val, mem_addr, pair_lo, pair_hi;
    logic [63:0] mem_rdata;
    int n_errors = 0, total_checks = 0, cyc = 0;

    lda_top u_lda_top (.*);
    lda_mem_model u_lda_mem_model (.*);

    // ==========================================================
    // Clock, timeout and shared tasks
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input string n, logic [63:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [31:0] mk(input logic [2:0] cr, logic z, logic [3:0] dst,
        logic sc, logic [4:0] b, o, logic [3:0] md, logic y, s);
        return {cr, z, dst, sc, b, o, md, 1'b1, y, LDST_UNALIGNED_DW, TAG_UNALIGNED, s, 1'b0};
    endfunction
    task load(input logic [31:0] w, bv, cv, logic go, logic [31:0] ea, logic ewe,
        logic [31:0] eb);
        @(posedge pclk);
        {iss_valid, iss_word, rf_base_val, cond_val} <= {1'b1, w, bv, cv};
        #1;
        chk("rf_side", rf_side, w[7]);
        chk("cond_sel", cond_sel, w[31:29]);
        @(posedge pclk);
        iss_valid <= 1'b0;
        #1;
        chk("mem_req", mem_req, go);
        if (go) begin
            chk("mem_addr", mem_addr, ea);
            chk("base_we", base_we, ewe);
            if (ewe) chk("base_val", base_val, eb);
            if (ewe) chk("base_dst", {base_side, base_idx}, {w[7], w[22:18]});
            chk("mem_unit", mem_unit, w[7]);
            chk("mem_unal", mem_unaligned, w[3:2] == TAG_UNALIGNED);
        end
        repeat (3) @(posedge pclk);
        #1;
        chk("pair_we", pair_we, go);
        if (go) begin
            chk("pair_data", {pair_hi, pair_lo}, u_lda_mem_model.fetch(ea));
            chk("pair_dst", {pair_side, pair_even_idx}, {w[1], w[27:24], 1'b0});
            chk("pair_odd", pair_odd_idx, {w[27:24], 1'b1});
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_regs;
        apb(1'b0, REG_AMR);
        chk("amr_reset", rd, AMR_RST);
        apb(1'b0, REG_CTRL);
        chk("ctrl_reset", rd, CTRL_RST);
        apb(1'b0, 12'h020);
        chk("unmapped", {er, rd}, 33'h1_0000_0000);
        $display("test regs done");
    endtask
    task t_modes;
        logic [31:0] o, s;
        for (int m = 0; m < 32; m++) begin
            if (m[3] == 1'b0 && m[1] == 1'b1) continue;
            o = 32'h5 << (m[4] ? 3 : 0);
            s = m[0] ? 32'h1003 + o : 32'h1003 - o;
            load(mk(3'h0, 1'b0, 4'(m), m[4], 5'd10, 5'd5, 4'(m), m[0], ~m[0]),
                32'h1003, 32'h0, 1'b1, m[1] ? 32'h1003 : s, m[3], s);
        end
        $display("test modes done");
    endtask
    task t_cond;
        logic [5:0] t [6];
        t = '{6'b001000, 6'b001101, 6'b000110, 6'b010011, 6'b011110, 6'b000001};
        for (int i = 0; i < 6; i++) begin
            load(mk(t[i][5:3], t[i][2], 4'h2, 1'b0, 5'd10, 5'd5, 4'b0101, 1'b0, 1'b0),
                32'h1003, {31'h0, t[i][1]}, t[i][0], 32'h1008, 1'b0, 32'h0);
        end
        $display("test cond done");
    endtask
    task t_circ;
        logic [31:0] w;
        apb(1'b1, REG_AMR, 32'h0003_0001);
        apb(1'b0, REG_AMR);
        chk("amr_rw", rd, 32'h0003_0001);
        w = mk(3'h0, 1'b0, 4'h4, 1'b1, 5'd4, 5'd1, 4'b1011, 1'b0, 1'b0);
        load(w, 32'h100c, 32'h0, 1'b1, 32'h100c, 1'b1, 32'h1004);
        w[7] = 1'b1;
        load(w, 32'h100c, 32'h0, 1'b1, 32'h100c, 1'b1, 32'h1014);
        apb(1'b1, REG_AMR, 32'h0);
        w = mk(3'h0, 1'b0, 4'h1, 1'b0, 5'd10, 5'd5, 4'b0001, 1'b0, 1'b1);
        w[6:2] = {LDST_ALIGNED_DW, TAG_ALIGNED};
        load(w, 32'h1003, 32'h0, 1'b1, 32'h1028, 1'b0, 32'h0);
        $display("test circular done");
    endtask
    task t_status;
        logic [31:0] w;
        w = mk(3'h0, 1'b0, 4'h3, 1'b0, 5'd10, 5'd5, 4'b0101, 1'b0, 1'b0);
        iss_other_mem <= 1'b1;
        load(w, 32'h1003, 32'h0, 1'b1, 32'h1008, 1'b0, 32'h0);
        iss_other_mem <= 1'b0;
        late <= 1'b1;
        load(w, 32'h1003, 32'h0, 1'b1, 32'h1008, 1'b0, 32'h0);
        late <= 1'b0;
        load(w ^ 32'h0000_0400, 32'h1003, 32'h0, 1'b0, 32'h0, 1'b0, 32'h0);
        apb(1'b0, REG_STATUS);
        chk("status", rd[2:0], 3'b111);
        apb(1'b1, REG_STATUS, 32'h7);
        apb(1'b0, REG_STATUS);
        chk("status_clr", rd[2:0], 3'b000);
        apb(1'b1, REG_CTRL);
        load(w, 32'h1003, 32'h0, 1'b0, 32'h0, 1'b0, 32'h0);
        apb(1'b0, REG_REFUSED);
        chk("refused", rd, 32'h1);
        apb(1'b1, REG_CTRL, 32'h1);
        $display("test status done");
    endtask

    initial begin
        {presetn, psel, penable, pwrite, iss_valid, iss_other_mem, late} = '0;
        {paddr, pwdata, iss_word, rf_base_val, cond_val} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_modes;
        t_cond;
        t_circ;
        t_status;
        end_sim;
    end
endmodule
`default_nettype wire
